// ### fld_register_map.sv
// register map of the flash led driver behind its two-wire serial slave
module fld_register_map import fld_pkg::*; #(
    parameter int         TICK_CYCLES = TICK_CYCLES_DEF,
    parameter logic [6:0] SLAVE_ADDR  = 7'h5a,  // arbitrary value
    parameter logic [7:0] CHIP_ID     = 8'ha5,  // arbitrary value
    parameter logic [7:0] PART_REV    = 8'h21   // arbitrary value
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       hardware_enable_pin,
    input  wire logic [6:0] fault_evt_primary,
    input  wire logic [4:0] fault_evt_secondary,
    input  wire logic [6:0] last_flash_code,
    output logic [7:0]      operating_control,
    output logic [6:0]      voltage_monitor_cfg,
    output logic [6:0]      led1_flash_code,
    output logic [6:0]      led2_flash_code,
    output logic [6:0]      led1_torch_code,
    output logic [6:0]      led2_torch_code,
    output logic [3:0]      converter_cfg,
    output logic [6:0]      ramp_timeout_cfg,
    output logic [6:0]      thermistor_pin_cfg,
    output logic [7:0]      fault_flags_primary,
    output logic [4:0]      fault_flags_secondary
);
    fld_regs_t  q;
    fld_regs_t  n;
    logic       tmr_exp;
    logic       scl_r;
    logic       scl_f;
    logic       start_c;
    logic       stop_c;
    logic       wr_en;
    logic       soft_rst;
    logic       rd_load;
    logic       clr1;
    logic       clr2;

    function automatic logic [7:0] read_byte(input fld_regs_t s, input logic [7:0] a);
        if (a == ADDR_CHIP_ID) begin
            read_byte = CHIP_ID;
        end else if (a <= ADDR_RW_LAST) begin
            read_byte = s.rw[a[3:0]] & RW_WMASK[a[3:0]];
        end else if (a == ADDR_FLAGS1) begin
            read_byte = s.flags1;
        end else if (a == ADDR_FLAGS2) begin
            read_byte = {3'h0, s.flags2};
        end else if (a == ADDR_PART_REV) begin
            read_byte = PART_REV;
        end else if (a == ADDR_LAST_FL) begin
            read_byte = {1'b0, last_flash_code};
        end else begin
            read_byte = 8'h00;
        end
    endfunction

    fld_flash_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clock   (clock),
        .rst_n   (rst_n),
        .run     (q.rw[1][MODE_LSB+1:MODE_LSB] == MODE_FLASH),
        .code    (q.rw[8][3:0]),
        .expired (tmr_exp)
    );

    always_comb begin
        n = q;
        wr_en    = 1'b0;
        soft_rst = 1'b0;
        rd_load  = 1'b0;
        clr1     = 1'b0;
        clr2     = 1'b0;
        // bus pins and fault lines are asynchronous: two flops before use
        n.scl_s = {q.scl_s[1:0], scl_in};
        n.sda_s = {q.sda_s[1:0], sda_in};
        n.evt_m = {hardware_enable_pin, fault_evt_secondary, fault_evt_primary};
        n.evt_s = q.evt_m;
        scl_r   = q.scl_s[1] & ~q.scl_s[2];
        scl_f   = ~q.scl_s[1] & q.scl_s[2];
        start_c = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
        stop_c  = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];

        if (start_c) begin
            n.st       = ST_RX;
            n.phase    = PH_ADDR;
            n.bcnt     = '0;
            n.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            n.st       = ST_IDLE;
            n.sda_oe_n = 1'b1;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    n.sda_oe_n = 1'b1;
                end
                ST_RX: begin
                    if (scl_r) begin
                        n.sh   = {q.sh[6:0], q.sda_s[1]};
                        n.bcnt = q.bcnt + 4'h1;
                    end else if (scl_f && q.bcnt == BITS_PER_BYTE) begin
                        n.bcnt = '0;
                        n.st   = ST_ACK;
                        n.sda_oe_n = 1'b0;
                        if (q.phase == PH_ADDR) begin
                            n.rd = q.sh[0];
                            if (q.sh[7:1] != SLAVE_ADDR) begin
                                n.st       = ST_IDLE;
                                n.sda_oe_n = 1'b1;
                            end
                        end else if (q.phase == PH_REG) begin
                            n.ptr = q.sh;
                        end else begin
                            wr_en = 1'b1;
                            n.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_f) begin
                        n.sda_oe_n = 1'b1;
                        if (q.phase == PH_ADDR && q.rd) begin
                            rd_load = 1'b1;
                        end else begin
                            n.st    = ST_RX;
                            n.phase = (q.phase == PH_ADDR) ? PH_REG : PH_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_f) begin
                        n.bcnt = q.bcnt + 4'h1;
                        n.sh   = {q.sh[6:0], 1'b0};
                        if (q.bcnt == BITS_PER_BYTE - 4'h1) begin
                            n.bcnt     = '0;
                            n.st       = ST_RACK;
                            n.sda_oe_n = 1'b1;
                        end else begin
                            n.sda_oe_n = q.sh[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_r) begin
                        // a missing acknowledge ends the read until the next start
                        if (!q.sda_s[1]) begin
                            n.ptr = q.ptr + 8'h01;
                            n.st  = ST_RLOAD;
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end
                end
                ST_RLOAD: begin
                    if (scl_f) begin
                        rd_load = 1'b1;
                    end
                end
                default: begin
                    n.st       = ST_IDLE;
                    n.sda_oe_n = 1'b1;
                end
            endcase
        end

        if (rd_load) begin
            n.sh       = read_byte(q, q.ptr);
            n.sda_oe_n = n.sh[7];
            n.bcnt     = '0;
            n.st       = ST_TX;
            clr1       = (q.ptr == ADDR_FLAGS1);
            clr2       = (q.ptr == ADDR_FLAGS2);
        end

        if (wr_en && q.ptr >= ADDR_CTRL && q.ptr <= ADDR_RW_LAST) begin
            // reserved bits are masked off; read-only addresses fall outside
            n.rw[q.ptr[3:0]] = q.sh & RW_WMASK[q.ptr[3:0]];
            soft_rst = (q.ptr == ADDR_CONV) && q.sh[SWRST_BIT];
        end
        if (soft_rst) begin
            n.rw = RW_RESET;
        end
        if (tmr_exp) begin
            n.rw[1][MODE_LSB+1:MODE_LSB] = MODE_STANDBY;
        end

        // hardware sets win over every kind of clear
        if (clr1 || soft_rst || !q.evt_s[12]) begin
            n.flags1 = FLAGS_RST;
        end
        if (clr2 || soft_rst || !q.evt_s[12]) begin
            n.flags2 = '0;
        end
        n.flags1 = n.flags1 | {q.evt_s[6:0], tmr_exp};
        n.flags2 = n.flags2 | q.evt_s[11:7];

        n.led2_flash = q.rw[3][OVERRIDE_BIT] ? q.rw[3][6:0] : q.rw[4][6:0];
        n.led2_torch = q.rw[5][OVERRIDE_BIT] ? q.rw[5][6:0] : q.rw[6][6:0];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q            <= '0;
            q.scl_s      <= 3'h7;
            q.sda_s      <= 3'h7;
            q.evt_m      <= 13'h1000;
            q.evt_s      <= 13'h1000;
            q.st         <= ST_IDLE;
            q.sda_oe_n   <= 1'b1;
            q.rw         <= RW_RESET;
            q.led2_flash <= RW_RESET[3][6:0];
            q.led2_torch <= RW_RESET[5][6:0];
        end else begin
            q <= n;
        end
    end

    assign sda_out               = 1'b0;
    assign sda_oe_n              = q.sda_oe_n;
    assign operating_control     = q.rw[1];
    assign voltage_monitor_cfg   = q.rw[2][6:0];
    assign led1_flash_code       = q.rw[3][6:0];
    assign led2_flash_code       = q.led2_flash;
    assign led1_torch_code       = q.rw[5][6:0];
    assign led2_torch_code       = q.led2_torch;
    assign converter_cfg         = q.rw[7][3:0];
    assign ramp_timeout_cfg      = q.rw[8][6:0];
    assign thermistor_pin_cfg    = q.rw[9][6:0];
    assign fault_flags_primary   = q.flags1;
    assign fault_flags_secondary = q.flags2;

    property p_ctrl_reset;
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> operating_control == CTRL_RST;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not at reset value");

    property p_flash_override;
        @(posedge clock) disable iff (!rst_n)
        q.rw[3][OVERRIDE_BIT] |=> led2_flash_code == $past(led1_flash_code);
    endproperty
    a_flash_override: assert property (p_flash_override) else $error("flash override lost");

    property p_torch_own;
        @(posedge clock) disable iff (!rst_n)
        !q.rw[5][OVERRIDE_BIT] |=> led2_torch_code == $past(q.rw[6][6:0]);
    endproperty
    a_torch_own: assert property (p_torch_own) else $error("torch code not own");

    property p_soft_reset;
        @(posedge clock) disable iff (!rst_n)
        soft_rst |=> operating_control == CTRL_RST && converter_cfg == RW_RESET[7][3:0]
                     && fault_flags_primary == {$past(q.evt_s[6:0]), $past(tmr_exp)};
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

    property p_timeout_end;
        @(posedge clock) disable iff (!rst_n)
        tmr_exp |-> $past(operating_control[3:2]) == MODE_FLASH
                    ##1 operating_control[3:2] == MODE_STANDBY && fault_flags_primary[FLAG_TMO_BIT];
    endproperty
    a_timeout_end: assert property (p_timeout_end) else $error("flash not ended");

    property p_flag_sticky;
        @(posedge clock) disable iff (!rst_n)
        q.evt_s[0] || (fault_flags_primary[1] && !clr1 && !soft_rst && q.evt_s[12])
            |=> fault_flags_primary[1];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag set lost");

    property p_read_clear;
        @(posedge clock) disable iff (!rst_n)
        clr1 && q.evt_s[6:0] == 7'h00 && !tmr_exp |=> fault_flags_primary == FLAGS_RST;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

    property p_ptr_advance;
        @(posedge clock) disable iff (!rst_n)
        wr_en && !start_c |=> q.ptr == $past(q.ptr) + 8'h01 ##1 q.st == ST_ACK;
    endproperty
    a_ptr_advance: assert property (p_ptr_advance) else $error("pointer not advanced");

    property p_reserved_zero;
        @(posedge clock) disable iff (!rst_n)
        q.rw[2][7] == 1'b0 && q.rw[7][7:4] == 4'h0 && q.rw[4][7] == 1'b0 && q.rw[9][7] == 1'b0
        && q.rw[6][7] == 1'b0 && q.rw[8][7] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_hardware_enable_pin_clear;
        @(posedge clock) disable iff (!rst_n)
        !q.evt_s[12] && q.evt_s[6:0] == 7'h00 && !tmr_exp |=> fault_flags_primary == FLAGS_RST;
    endproperty
    a_hardware_enable_pin_clear: assert property (p_hardware_enable_pin_clear) else $error("enable pin clear lost");

    property p_read_advance;
        @(posedge clock) disable iff (!rst_n)
        q.st == ST_RACK && scl_r && !q.sda_s[1] |=> q.ptr == $past(q.ptr) + 8'h01;
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("read pointer stuck");

    property p_conv_wr;
        @(posedge clock) disable iff (!rst_n)
        wr_en && q.ptr == ADDR_CONV && !q.sh[SWRST_BIT] |=> converter_cfg == $past(q.sh[3:0]);
    endproperty
    a_conv_wr: assert property (p_conv_wr) else $error("cfg lost");

    c_write: cover property (@(posedge clock) disable iff (!rst_n) wr_en);
    c_flag_read: cover property (@(posedge clock) disable iff (!rst_n) clr1);
    c_timeout: cover property (@(posedge clock) disable iff (!rst_n) tmr_exp);
    c_soft_reset: cover property (@(posedge clock) disable iff (!rst_n) soft_rst);
    c_read_ack: cover property (@(posedge clock) disable iff (!rst_n) q.st == ST_RACK && scl_r);
endmodule // fld_register_map

// ### fld_pkg.sv
// shared constants, types and tables for the flash led driver register map
package fld_pkg;
    // timing
    localparam int CLK_PERIOD_NS   = 50;
    localparam int TIMEOUT_TICK_MS = 1;
    localparam int TICK_CYCLES_DEF = TIMEOUT_TICK_MS * 1000000 / CLK_PERIOD_NS;

    // register offsets
    localparam logic [7:0] ADDR_CHIP_ID  = 8'h00;
    localparam logic [7:0] ADDR_CTRL     = 8'h01;
    localparam logic [7:0] ADDR_CONV     = 8'h07;
    localparam logic [7:0] ADDR_RW_LAST  = 8'h09;
    localparam logic [7:0] ADDR_FLAGS1   = 8'h0a;
    localparam logic [7:0] ADDR_FLAGS2   = 8'h0b;
    localparam logic [7:0] ADDR_PART_REV = 8'h0c;
    localparam logic [7:0] ADDR_LAST_FL  = 8'h0d;

    // reset values and writable-bit masks of the read/write registers 0x09..0x01
    localparam logic [9:1][7:0] RW_RESET = {8'h08, 8'h1a, 8'h09, 8'h3f, 8'hbf,
                                            8'h3f, 8'hbf, 8'h01, 8'h80};
    localparam logic [9:1][7:0] RW_WMASK = {8'h7f, 8'h7f, 8'h0f, 8'h7f, 8'hff,
                                            8'h7f, 8'hff, 8'h7f, 8'hff};
    localparam logic [7:0] CTRL_RST  = 8'h80;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // field positions
    localparam int MODE_LSB      = 2;
    localparam int OVERRIDE_BIT  = 7;
    localparam int SWRST_BIT     = 7;
    localparam int FLAG_TMO_BIT  = 0;
    localparam logic [1:0] MODE_STANDBY = 2'b00;
    localparam logic [1:0] MODE_IR      = 2'b01;
    localparam logic [1:0] MODE_TORCH   = 2'b10;
    localparam logic [1:0] MODE_FLASH   = 2'b11;

    // serial engine
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] PH_ADDR = 2'd0;
    localparam logic [1:0] PH_REG  = 2'd1;
    localparam logic [1:0] PH_DATA = 2'd2;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK, ST_RLOAD} fld_state_e_t;

    typedef struct packed {
        logic [2:0]       scl_s;
        logic [2:0]       sda_s;
        logic [12:0]      evt_m;
        logic [12:0]      evt_s;
        fld_state_e_t     st;
        logic [1:0]       phase;
        logic [3:0]       bcnt;
        logic [7:0]       sh;
        logic [7:0]       ptr;
        logic             rd;
        logic             sda_oe_n;
        logic [9:1][7:0]  rw;
        logic [7:0]       flags1;
        logic [4:0]       flags2;
        logic [6:0]       led2_flash;
        logic [6:0]       led2_torch;
    } fld_regs_t;

    typedef struct packed {
        logic [15:0] tick;
        logic [10:0] ms;
        logic        done;
        logic        expired;
    } fld_tmr_t;

    // flash timeout duration in ms for each 4-bit code
    function automatic logic [10:0] fld_timeout_ms(input logic [3:0] code);
        case (code)
            4'h0:    fld_timeout_ms = 11'd40;
            4'h1:    fld_timeout_ms = 11'd80;
            4'h2:    fld_timeout_ms = 11'd120;
            4'h3:    fld_timeout_ms = 11'd160;
            4'h4:    fld_timeout_ms = 11'd200;
            4'h5:    fld_timeout_ms = 11'd240;
            4'h6:    fld_timeout_ms = 11'd280;
            4'h7:    fld_timeout_ms = 11'd320;
            4'h8:    fld_timeout_ms = 11'd360;
            4'h9:    fld_timeout_ms = 11'd400;
            4'ha:    fld_timeout_ms = 11'd600;
            4'hb:    fld_timeout_ms = 11'd800;
            4'hc:    fld_timeout_ms = 11'd1000;
            4'hd:    fld_timeout_ms = 11'd1200;
            4'he:    fld_timeout_ms = 11'd1400;
            default: fld_timeout_ms = 11'd1600;
        endcase
    endfunction
endpackage

// ### fld_flash_timer.sv
// flash timeout timer: millisecond divider and duration compare
module fld_flash_timer import fld_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [3:0] code,
    output logic            expired
);
    fld_tmr_t q;
    fld_tmr_t n;

    always_comb begin
        n = q;
        n.expired = 1'b0;
        if (!run) begin
            n.tick = '0;
            n.ms   = '0;
            n.done = 1'b0;
        end else if (!q.done) begin
            if (q.tick == 16'(TICK_CYCLES - 1)) begin
                n.tick = '0;
                n.ms   = q.ms + 11'd1;
                // one pulse per flash; run must drop before the next flash can time out
                if (n.ms >= fld_timeout_ms(code)) begin
                    n.done    = 1'b1;
                    n.expired = 1'b1;
                end
            end else begin
                n.tick = q.tick + 16'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign expired = q.expired;
endmodule // fld_flash_timer

// ### fld_host_model.sv
// host model: two-wire serial bus master that reaches the register map
module fld_host_model (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus: clock parked high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // a 400 ns bit: data moves two clocks into the low phase, and an ack that the
    // device lets go of three clocks after the fall still settles before scl rises
    task automatic bitx(input logic b, output logic r);
        tick(2);
        sda_drv = b;
        tick(2);
        scl = 1'b1;
        tick(4);
        r = sda_line;
        scl = 1'b0;
    endtask

    task automatic start();
        // a repeated start lets the device drop its ack before sda and scl rise
        tick(2);
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(4);
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask

    task automatic xfer(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask

    task automatic rx(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            b[i] = r;
        end
        bitx(last, r);
    endtask

    task automatic write(input logic [6:0] adr, input logic [7:0] ptr,
                         input logic [7:0] d [$], output logic ok);
        logic a;
        start();
        xfer({adr, 1'b0}, ok);
        xfer(ptr, a);
        foreach (d[i]) xfer(d[i], a);
        stop();
    endtask

    task automatic read(input logic [6:0] adr, input logic [7:0] ptr, input int n,
                        output logic [7:0] q [$], output logic ok);
        logic       a;
        logic [7:0] b;
        start();
        xfer({adr, 1'b0}, ok);
        xfer(ptr, a);
        start();
        xfer({adr, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            rx(i == n - 1, b);
            q.push_back(b);
        end
        stop();
    endtask
endmodule // fld_host_model

// ### test_fld_register_map.sv
// self-checking bench of the flash led driver register map
module test_fld_register_map;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0]  ADR  = 7'h2d;  // arbitrary value
    localparam logic [7:0]  CHIP = 8'hc3;  // arbitrary value
    localparam logic [7:0]  PREV = 8'h4b;  // arbitrary value
    localparam logic [52:0] CFG_RST = {7'h01, 7'h3f, 7'h3f, 7'h3f, 7'h3f, 4'h9, 7'h1a, 7'h08};
    localparam logic [7:0]  RST_TAB [15] = '{CHIP, 8'h80, 8'h01, 8'hbf, 8'h3f, 8'hbf, 8'h3f,
                                             8'h09, 8'h1a, 8'h08, 8'h00, 8'h00, PREV, 8'h00, 8'h00};

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        hardware_enable_pin = 1'b1;
    logic [6:0]  fault_evt_primary = 7'h00;
    logic [4:0]  fault_evt_secondary = 5'h00;
    logic [6:0]  last_flash_code = 7'h00;
    logic        scl, sda_drv, sda_out, sda_oe_n;
    logic [7:0]  operating_control, fault_flags_primary;
    logic [6:0]  voltage_monitor_cfg, led1_flash_code, led2_flash_code, led1_torch_code;
    logic [6:0]  led2_torch_code, ramp_timeout_cfg, thermistor_pin_cfg;
    logic [3:0]  converter_cfg;
    logic [4:0]  fault_flags_secondary;
    wire  logic  sda = sda_drv & (sda_oe_n | sda_out);
    wire  logic [52:0] cfg_bus = {voltage_monitor_cfg, led1_flash_code, led2_flash_code,
        led1_torch_code, led2_torch_code, converter_cfg, ramp_timeout_cfg, thermistor_pin_cfg};
    int          miscompares = 0;
    int          tests_run = 0;

    always #25 clock = ~clock;

    fld_host_model u_fld_host_model (.clock, .sda_line(sda), .scl, .sda_drv);

    fld_register_map #(.TICK_CYCLES(20), .SLAVE_ADDR(ADR), .CHIP_ID(CHIP), .PART_REV(PREV))
    u_fld_register_map (.clock, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
        .hardware_enable_pin, .fault_evt_primary, .fault_evt_secondary, .last_flash_code,
        .operating_control, .voltage_monitor_cfg, .led1_flash_code, .led2_flash_code,
        .led1_torch_code, .led2_torch_code, .converter_cfg, .ramp_timeout_cfg,
        .thermistor_pin_cfg, .fault_flags_primary, .fault_flags_secondary);

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t ns: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
        logic ok;
        u_fld_host_model.write(ADR, ptr, d, ok);
        chk(ok, 1'b1);
    endtask

    task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q [$]);
        logic ok;
        u_fld_host_model.read(ADR, ptr, n, q, ok);
        chk(ok, 1'b1);
    endtask

    task automatic t_reset();
        logic [7:0] q [$];
        chk(operating_control, 8'h80);
        chk(cfg_bus, CFG_RST);
        rd(8'h00, 15, q);
        for (int i = 0; i < 15; i++) chk(q[i], RST_TAB[i]);
    endtask

    task automatic t_burst();
        logic [7:0] q [$];
        logic [7:0] e [13] = '{8'hf3, 8'h7f, 8'hff, 8'h7f, 8'hff, 8'h7f, 8'h0f,
                               8'h7f, 8'h7f, 8'h00, 8'h00, PREV, 8'h2a};
        last_flash_code = 7'h2a;
        // 0x07 bit 7 kept clear: a set bit would reset the whole map mid-burst
        wr(8'h01, {8'hf3, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff,
                   8'hff, 8'hff, 8'hff});
        chk(operating_control, 8'hf3);
        chk(cfg_bus, {7'h7f, 7'h7f, 7'h7f, 7'h7f, 7'h7f, 4'hf, 7'h7f, 7'h7f});
        rd(8'h01, 13, q);
        for (int i = 0; i < 13; i++) chk(q[i], e[i]);
    endtask

    task automatic t_override();
        wr(8'h03, {8'h05, 8'h0c, 8'h06, 8'h0d});
        chk({led2_flash_code, led2_torch_code}, {7'h0c, 7'h0d});
        wr(8'h03, {8'h85, 8'h0c, 8'h86});
        chk({led1_flash_code, led2_flash_code, led2_torch_code}, {7'h05, 7'h05, 7'h06});
    endtask

    task automatic t_modes();
        logic [7:0] q [$];
        int         n;
        for (int m = 0; m < 3; m++) begin
            wr(8'h01, {8'(m * 4 + 3)});
            chk(operating_control, 8'(m * 4 + 3));
        end
        wr(8'h08, {8'h10});
        wr(8'h01, {8'h0c});
        chk(operating_control, 8'h0c);
        n = 0;
        while (operating_control[3:2] !== 2'b00 && n < 1000) begin
            tick(1);
            n++;
        end
        // 40 ms at 20 clocks per ms, less the ack and stop after the update
        chk(n >= 760 && n <= 800, 1'b1);
        chk(fault_flags_primary, 8'h01);
        rd(8'h0a, 1, q);
        chk(q[0], 8'h01);
        chk(fault_flags_primary, 8'h00);
    endtask

    task automatic t_flags();
        logic [7:0] q [$];
        logic       ok;
        fault_evt_primary = 7'h55;
        fault_evt_secondary = 5'h15;
        tick(6);
        fault_evt_primary = 7'h00;
        fault_evt_secondary = 5'h00;
        rd(8'h0a, 2, q);
        chk({q[0], q[1]}, {8'haa, 8'h15});
        chk({fault_flags_primary, fault_flags_secondary}, 13'h0);
        fault_evt_primary = 7'h7f;
        tick(6);
        fault_evt_primary = 7'h00;
        chk(fault_flags_primary, 8'hfe);
        hardware_enable_pin = 1'b0;
        tick(4);
        hardware_enable_pin = 1'b1;
        tick(4);
        chk(fault_flags_primary, 8'h00);
        fault_evt_primary = 7'h01;
        tick(6);
        fault_evt_primary = 7'h00;
        wr(8'h07, {8'h80});
        chk({operating_control, fault_flags_primary}, 16'h8000);
        chk(cfg_bus, CFG_RST);
        rd(8'h07, 1, q);
        chk(q[0], 8'h09);
        u_fld_host_model.write(ADR ^ 7'h01, 8'h01, {8'h55}, ok);
        chk({ok, operating_control}, 9'h080);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        tick(4);
        t_reset();
        t_burst();
        t_override();
        t_modes();
        t_flags();
        stop_test();
    end

    // the sequence needs well under 1 ms of bus traffic
    initial begin
        #3000000;
        miscompares++;
        stop_test();
    end
endmodule // test_fld_register_map
